/* File: hdl/dpc_map.svh */
// register offsets, field positions and reset values of the diagnostic and
// power-management capability group; included by the route and register modules
`ifndef DPC_MAP_SVH
`define DPC_MAP_SVH
`define DPC_OFS_DIAG 8'h93
`define DPC_OFS_CAP_ID 8'hA0
`define DPC_OFS_CAP_NEXT 8'hA1
`define DPC_OFS_PMCAP_LO 8'hA2
`define DPC_OFS_PMCAP_HI 8'hA3
`define DPC_OFS_VENDOR_LO 8'h00
`define DPC_OFS_DEVICE_HI 8'h03
`define DPC_DIAG_RESET 8'h60
`define DPC_CAP_ID_VAL 8'h01
`define DPC_CAP_NEXT_VAL 8'h00
`define DPC_PMCAP_RESET 16'hFE12
`define DPC_BIT_IDMASK 7
`define DPC_BIT_FIXED1 6
`define DPC_BIT_ROUTE 5
`define DPC_BIT_DTDIS 4
`define DPC_BIT_RETRY 3
`define DPC_BIT_CARDTIM 2
`define DPC_BIT_HOSTTIM 1
`define DPC_BIT_RSVD0 0
`define DPC_DIAG_WMASK 8'hBF
`define DPC_PMCAP_WBIT 15
`define DPC_PMCAP_WBIT_RESET 1'b1
`define DPC_RETRY_SHORT 7'h10
`define DPC_RETRY_LONG 7'h40
`define DPC_DISCARD_SHORT_LOG2 5'h0A
`define DPC_DISCARD_LONG_LOG2 5'h0F
`define DPC_LSR_IRQ_BIT 4
`endif

/* File: hdl/dpc_pkg.sv */
// types shared by the capability register group
// assumes dpc_map.svh is on the include path
package dpc_pkg;
    // one configuration access, byte addressed, byte enables per lane
    typedef struct packed {
        logic [7:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } dpc_cfg_req_s;
    // settings that steer the bridge's transaction logic
    typedef struct packed {
        logic delayed_txn_off;
        logic [6:0] retry_limit;
        logic [4:0] card_discard_log2;
        logic [4:0] host_discard_log2;
        logic identity_read_mask;
    } dpc_ctrl_s;
endpackage

/* File: hdl/dpc_route.sv */
// status-change interrupt routing decision
// assumes legacy socket register images arrive from the socket block
`timescale 1ns/1ps
`default_nettype none
`include "dpc_map.svh"
module dpc_route (
    // select and legacy socket images
    input wire logic status_change_route_select,
    input wire logic [7:0] lsr_803,
    input wire logic [7:0] lsr_805,
    // decision
    output logic route_to_host
);
    // select high ignores 803, select low ignores 805
    always_comb begin
        if (status_change_route_select) begin
            route_to_host = (lsr_805[7:4] == 4'h0);
        end else begin
            route_to_host = lsr_803[`DPC_LSR_IRQ_BIT];
        end
    end
endmodule
`default_nettype wire

/* File: hdl/dpc_regs.sv */
// diagnostic register and power-management capability structure
// assumes configuration requests synchronous to sys_clk, one per cycle
//
// Summary of operation
// - identity mask bit forces identity reads all ones
// - diagnostic bit 6 always reads one
// - select clear: route when socket 803 bit4
// - select set: route when 805 bits7-4 zero
// - bit 4 disables delayed transactions
// - bit 3 stretches retry limit 16 to 64
// - bit 2 picks card discard 2^10 or 2^15
// - bit 1 picks host discard 2^10 or 2^15
// - capability_list_id reads 01h, read only
// - next pointer reads zero, last item
// - capabilities reset FE12h, only bit 15 writable
// - capabilities advertise D0 to D3 support
`timescale 1ns/1ps
`default_nettype none
`include "dpc_map.svh"
module dpc_regs
    import dpc_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // configuration access
    input wire dpc_cfg_req_s cfg_req,
    output logic [31:0] cfg_rdata,
    output logic cfg_rvalid,
    // true identity word of the function, offset 00h
    input wire logic [31:0] identity_word,
    // legacy socket images for status-change routing
    input wire logic [7:0] lsr_803,
    input wire logic [7:0] lsr_805,
    input wire logic status_change_event,
    // steering outputs
    output dpc_ctrl_s ctrl,
    output logic status_change_irq
);
    // the dword decode below is written for 8-bit offsets only
    if (ADDR_W != 8) begin : g_addr_w_check
        $error("dpc_regs serves 8-bit configuration offsets only");
    end

    logic [7:0] diag_q, diag_d;
    logic pm_wbit_q, pm_wbit_d;
    logic [31:0] rdata_q, rdata_d;
    logic rvalid_q, rvalid_d;
    logic route_ok;
    logic [7:0] diag_rd;
    logic [15:0] pmcap_rd;
    logic [7:0] dword;

    // dword index of the access; lanes then pick bytes
    assign dword = {cfg_req.addr[7:2], 2'b00};

    // bit 6 is forced; the stored copy is never consulted for it
    always_comb begin
        diag_rd = diag_q;
        diag_rd[`DPC_BIT_FIXED1] = 1'b1;
    end

    // all fixed bits come from the reset constant, only bit 15 stored
    always_comb begin
        pmcap_rd = `DPC_PMCAP_RESET;
        pmcap_rd[`DPC_PMCAP_WBIT] = pm_wbit_q;
    end

    // write side: byte lane 3 of each of the two dwords we own
    always_comb begin
        diag_d = diag_q;
        pm_wbit_d = pm_wbit_q;
        if (cfg_req.wr && dword == (`DPC_OFS_DIAG & 8'hFC)
                && cfg_req.be[3]) begin
            // mask keeps bit 6 out of storage
            diag_d = (cfg_req.wdata[31:24] & `DPC_DIAG_WMASK)
                   | (diag_q & ~`DPC_DIAG_WMASK);
        end
        if (cfg_req.wr && dword == `DPC_OFS_CAP_ID && cfg_req.be[3]) begin
            pm_wbit_d = cfg_req.wdata[31];
        end
    end

    // read side: one cycle latency, unmapped bytes read zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        rvalid_d = cfg_req.rd;
        if (cfg_req.rd) begin
            unique case (dword)
                (`DPC_OFS_VENDOR_LO & 8'hFC): begin
                    if (diag_q[`DPC_BIT_IDMASK]) begin
                        rdata_d = 32'hFFFF_FFFF;
                    end else begin
                        rdata_d = identity_word;
                    end
                end
                (`DPC_OFS_DIAG & 8'hFC): begin
                    rdata_d = {diag_rd, 24'h00_0000};
                end
                `DPC_OFS_CAP_ID: begin
                    rdata_d = {pmcap_rd, `DPC_CAP_NEXT_VAL, `DPC_CAP_ID_VAL};
                end
                default: begin
                    rdata_d = 32'h0000_0000;
                end
            endcase
        end
    end

    // register state; writable bits return to reset values
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            diag_q <= `DPC_DIAG_RESET;
            pm_wbit_q <= `DPC_PMCAP_WBIT_RESET;
            rdata_q <= 32'h0000_0000;
            rvalid_q <= 1'b0;
        end else begin
            diag_q <= diag_d;
            pm_wbit_q <= pm_wbit_d;
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    assign cfg_rdata = rdata_q;
    assign cfg_rvalid = rvalid_q;

    // steering of the bridge's transaction engine
    always_comb begin
        ctrl.delayed_txn_off = diag_q[`DPC_BIT_DTDIS];
        ctrl.retry_limit = diag_q[`DPC_BIT_RETRY] ?
            `DPC_RETRY_LONG : `DPC_RETRY_SHORT;
        ctrl.card_discard_log2 = diag_q[`DPC_BIT_CARDTIM] ?
            `DPC_DISCARD_SHORT_LOG2 : `DPC_DISCARD_LONG_LOG2;
        ctrl.host_discard_log2 = diag_q[`DPC_BIT_HOSTTIM] ?
            `DPC_DISCARD_SHORT_LOG2 : `DPC_DISCARD_LONG_LOG2;
        ctrl.identity_read_mask = diag_q[`DPC_BIT_IDMASK];
    end

    // routing decision kept apart so the socket block can reuse it
    dpc_route u_route (
        .status_change_route_select(diag_q[`DPC_BIT_ROUTE]),
        .lsr_803(lsr_803),
        .lsr_805(lsr_805),
        .route_to_host(route_ok)
    );

    // combinational so the event is not delayed on its way to the host
    assign status_change_irq = status_change_event & route_ok;

    // reserved bit 0 and the zero-write convention are software's
    // business hardware stores bit 0 like any other

    // properties share the bus clock and reset; a read is judged one
    // cycle after its request, where the answer stands for the bus
    sequence diag_wr_s;
        cfg_req.wr && dword == 8'h90 && cfg_req.be[3];
    endsequence

    sequence pm_wr_s;
        cfg_req.wr && dword == 8'hA0 && cfg_req.be[3];
    endsequence

    sequence rd_at_s(logic [7:0] a);
        cfg_req.rd && dword == a;
    endsequence

    // identity dword: all ones while masked, the true word otherwise
    id_mask_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        rd_at_s(8'h00) ##0 diag_q[7] |=> cfg_rdata == 32'hFFFF_FFFF)
        else $error("identity read not masked");

    id_true_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        rd_at_s(8'h00) ##0 !diag_q[7] |=> cfg_rdata == $past(identity_word))
        else $error("identity read not true");

    mask_flag_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        ctrl.identity_read_mask == diag_q[7])
        else $error("identity mask flag wrong");

    // the fixed bit reads one whatever was written
    fixed_one_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        rd_at_s(8'h90) |=> cfg_rvalid && cfg_rdata[30])
        else $error("diagnostic bit 6 read zero");

    // stored copy keeps bit 6 set, the write mask never touches it
    diag_store_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        diag_wr_s |=> diag_q == (($past(cfg_req.wdata[31:24]) & 8'hBF)
            | 8'h40))
        else $error("diagnostic write not stored");

    diag_hold_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        !(cfg_req.wr && dword == 8'h90 && cfg_req.be[3])
            |=> $stable(diag_q))
        else $error("diagnostic changed without a write");

    // routing, as a whole and per value of the select
    route_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        status_change_irq == (status_change_event && (diag_q[5] ?
            lsr_805[7:4] == 4'h0 : lsr_803[4])))
        else $error("status change routed wrongly");

    route_803_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        status_change_event && !diag_q[5]
            |-> status_change_irq == lsr_803[4])
        else $error("socket bit 4 routing wrong");

    route_805_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        status_change_event && diag_q[5]
            |-> status_change_irq == (lsr_805[7:4] == 4'h0))
        else $error("socket nibble routing wrong");

    route_quiet_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        !status_change_event |-> !status_change_irq)
        else $error("status change raised with no event");

    route_sel_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        diag_wr_s |=> diag_q[5] == $past(cfg_req.wdata[29]))
        else $error("routing select not stored");

    // steering outputs follow the stored bits one cycle after a write
    retry_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        diag_wr_s |=> ctrl.retry_limit ==
            ($past(cfg_req.wdata[27]) ? 7'h40 : 7'h10)
            && ctrl.delayed_txn_off == $past(cfg_req.wdata[28]))
        else $error("retry or delayed setting wrong");

    dt_flag_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        ctrl.delayed_txn_off == diag_q[4])
        else $error("delayed transaction flag wrong");

    discard_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        ctrl.card_discard_log2 == (diag_q[2] ? 5'h0A : 5'h0F)
        && ctrl.host_discard_log2 == (diag_q[1] ? 5'h0A : 5'h0F))
        else $error("discard timer select wrong");

    card_timer_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        diag_wr_s |=> ctrl.card_discard_log2 ==
            ($past(cfg_req.wdata[26]) ? 5'h0A : 5'h0F))
        else $error("card discard length not taken");

    host_timer_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        diag_wr_s |=> ctrl.host_discard_log2 ==
            ($past(cfg_req.wdata[25]) ? 5'h0A : 5'h0F))
        else $error("host discard length not taken");

    // capability dword: fixed id, fixed link, one stored bit
    cap_const_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        rd_at_s(8'hA0) |=> cfg_rdata[15:0] == 16'h0001
            && cfg_rdata[30:16] == 15'h7E12)
        else $error("capability constants wrong");

    next_zero_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        rd_at_s(8'hA0) |=> cfg_rdata[15:8] == 8'h00)
        else $error("next pointer not zero");

    pm_wbit_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        pm_wr_s |=> pm_wbit_q == $past(cfg_req.wdata[31]))
        else $error("capability bit 15 not writable");

    pm_hold_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        !(cfg_req.wr && dword == 8'hA0 && cfg_req.be[3])
            |=> $stable(pm_wbit_q))
        else $error("capability bit 15 changed without a write");

    pm_read_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        rd_at_s(8'hA0) |=> cfg_rdata[31] == $past(pm_wbit_q))
        else $error("capability bit 15 read wrong");

    // read answers: one-cycle pulse, zero data when idle or unmapped
    rvalid_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        cfg_req.rd |=> cfg_rvalid)
        else $error("read not answered after one cycle");

    idle_zero_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        !cfg_req.rd |=> !cfg_rvalid && cfg_rdata == 32'h0000_0000)
        else $error("read answer without a request");

    unmapped_zero_a: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        cfg_req.rd && dword != 8'h00 && dword != 8'h90 && dword != 8'hA0
            |=> cfg_rdata == 32'h0000_0000)
        else $error("unmapped dword read nonzero");
endmodule
`default_nettype wire

/* File: verif/dpc_host_model.sv */
// host bus master model issuing configuration reads and writes
// assumes the register group answers reads one cycle after the request
`timescale 1ns/1ps
`default_nettype none
module dpc_host_model
    import dpc_pkg::*;
(
    // clock
    input wire logic sys_clk,
    // configuration access
    output var dpc_cfg_req_s cfg_req,
    input wire logic [31:0] cfg_rdata,
    input wire logic cfg_rvalid
);
    initial cfg_req = '0;

    // one access: request for one cycle, then wait a bounded time for data
    task automatic access(input logic wr, input logic [7:0] a,
                          input logic [3:0] be, input logic [31:0] d,
                          output logic [31:0] q, output logic ok,
                          output int lat);
        int n;
        q = '0;
        ok = wr;
        lat = 0;
        @(negedge sys_clk);
        cfg_req = '{a, be, d, wr, ~wr};
        @(negedge sys_clk);
        // released lines toggle so stale values never look valid
        cfg_req = '{~a, ~be, ~d, 1'b0, 1'b0};
        for (n = 0; n < 4 && !ok; n++) begin
            if (cfg_rvalid === 1'b1) begin
                q = cfg_rdata;
                ok = 1'b1;
                lat = n;
            end else begin
                @(negedge sys_clk);
            end
        end
    endtask
endmodule
`default_nettype wire

/* File: verif/diag_and_pm_capability_regs_tb.sv */
// self-checking bench for the diagnostic and capability register group
// assumes dpc_map.svh on the include path; inputs move at falling edges
`timescale 1ns/1ps
`default_nettype none
module diag_and_pm_capability_regs_tb;
    import dpc_pkg::*;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    dpc_cfg_req_s cfg_req;
    logic [31:0] cfg_rdata, q;
    logic cfg_rvalid;
    logic [31:0] identity_word = 32'h1234ABCD;
    logic [7:0] lsr_803 = 8'h00;
    logic [7:0] lsr_805 = 8'h00;
    logic status_change_event = 1'b0;
    dpc_ctrl_s ctrl;
    logic status_change_irq;
    int fail_count = 0;
    int n_checks = 0;

    always #5 sys_clk = ~sys_clk;

    dpc_host_model host (.sys_clk(sys_clk), .cfg_req(cfg_req),
        .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid));
    dpc_regs #(.ADDR_W(8)) dut (.sys_clk(sys_clk), .rstn(rstn),
        .cfg_req(cfg_req), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
        .identity_word(identity_word), .lsr_803(lsr_803), .lsr_805(lsr_805),
        .status_change_event(status_change_event), .ctrl(ctrl),
        .status_change_irq(status_change_irq));

    task automatic end_of_test;
        if (fail_count == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(string nm, logic [31:0] e, logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask

    // a read that never answers ends the run
    task automatic rd(input logic [7:0] a);
        logic ok;
        int lat;
        host.access(1'b0, a, 4'hF, 32'h0, q, ok, lat);
        check("read answer", 32'h1, {31'h0, ok});
        if (ok !== 1'b1) end_of_test();
        check("read latency", 32'h0, lat);
        // the answer stands one cycle, then the bus reads idle zeros
        @(negedge sys_clk);
        check("rvalid after read", 32'h0, {31'h0, cfg_rvalid});
        check("rdata after read", 32'h0, cfg_rdata);
    endtask

    task automatic wr(input logic [7:0] a, input logic [3:0] be,
                      input logic [31:0] d);
        logic [31:0] x;
        logic ok;
        int lat;
        host.access(1'b1, a, be, d, x, ok, lat);
    endtask

    task automatic t_reset_values;
        rd(8'hA0); check("cap dword", 32'hFE120001, q);
        rd(8'h90); check("diag", 32'h60, {24'h0, q[31:24]});
        check("ctrl", {13'h0, 1'b0, 7'h10, 5'h0F, 5'h0F, 1'b0}, 32'(ctrl));
    endtask

    // diag values keep reserved bit 0 at its reset value of 0
    task automatic t_diag_fields;
        wr(8'h90, 4'h8, 32'h9E000000);
        check("ctrl", {13'h0, 1'b1, 7'h40, 5'h0A, 5'h0A, 1'b1}, 32'(ctrl));
        rd(8'h90); check("diag", 32'hDE, {24'h0, q[31:24]});
        wr(8'h90, 4'h8, 32'h04000000);
        check("ctrl", {13'h0, 1'b0, 7'h10, 5'h0A, 5'h0F, 1'b0}, 32'(ctrl));
        wr(8'h90, 4'h7, 32'hFFFFFFFF);
        rd(8'h90); check("diag", 32'h44, {24'h0, q[31:24]});
    endtask

    task automatic t_identity;
        rd(8'h00); check("identity", 32'h1234ABCD, q);
        wr(8'h90, 4'h8, 32'h80000000);
        rd(8'h00); check("identity", 32'hFFFFFFFF, q);
        wr(8'h90, 4'h8, 32'h00000000);
        rd(8'h00); check("identity", 32'h1234ABCD, q);
    endtask

    task automatic t_pmcap;
        wr(8'hA0, 4'hF, 32'h00000000);
        rd(8'hA0); check("cap dword", 32'h7E120001, q);
        wr(8'hA0, 4'hF, 32'hFFFFFFFF);
        rd(8'hA0); check("cap dword", 32'hFE120001, q);
    endtask

    // the unused socket register always points the wrong way
    task automatic t_route;
        logic s, b;
        for (int i = 0; i < 4; i++) begin
            s = i[1];
            b = i[0];
            wr(8'h90, 4'h8, {2'b00, s, 29'h0});
            @(negedge sys_clk);
            lsr_803 = (b ^ s) ? 8'h10 : 8'hEF;
            lsr_805 = (b ^ s) ? 8'hF0 : 8'h0F;
            status_change_event = 1'b1;
            #1 check("irq", {31'h0, b}, {31'h0, status_change_irq});
            @(negedge sys_clk);
            status_change_event = 1'b0;
            #1 check("irq idle", 32'h0, {31'h0, status_change_irq});
        end
    endtask

    task automatic t_reset_mid;
        wr(8'h90, 4'h8, 32'h9E000000);
        wr(8'hA0, 4'hF, 32'h00000000);
        @(negedge sys_clk);
        rstn = 1'b0;
        @(negedge sys_clk);
        rstn = 1'b1;
        rd(8'h90); check("diag", 32'h60, {24'h0, q[31:24]});
        rd(8'hA0); check("cap dword", 32'hFE120001, q);
        rd(8'h40); check("unmapped", 32'h0, q);
    endtask

    initial begin
        repeat (2) @(negedge sys_clk);
        rstn = 1'b1;
        t_reset_values();
        t_diag_fields();
        t_identity();
        t_pmcap();
        t_route();
        t_reset_mid();
        end_of_test();
    end
endmodule
`default_nettype wire
